// ==== design/usbsw_pkg.sv ====
// package for the usb suspend, wake-up and interrupt block:
// register map, field positions, timing counts and link carriers.
// assumes a 20 MHz system clock and a 32-bit ahb-lite register bus.
package usbsw_pkg;

   // =========================================================
   // timing
   localparam int CLK_HZ = 20_000_000;
   localparam int IDLE_TIME_US = 3000; // bus silence before suspend
   localparam int IDLE_CYCLES = (IDLE_TIME_US * (CLK_HZ / 1_000_000));
   localparam int WAKE_TIME_US = 1000; // remote wake-up pulse length
   localparam int WAKE_CYCLES = (WAKE_TIME_US * (CLK_HZ / 1_000_000));

   // =========================================================
   // register byte offsets
   localparam logic [7:0] OFS_IRQC = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_CLOCK = 8'h08;
   localparam logic [7:0] OFS_IN_EN = 8'h0C;
   localparam logic [7:0] OFS_EP_IEN = 8'h10;
   localparam logic [7:0] OFS_EP_FLAG = 8'h14;
   localparam logic [7:0] OFS_PIPE0 = 8'h20; // pipes at 0x20 + 4*n
   localparam logic [7:0] OFS_PIPE_END = 8'h40;

   // =========================================================
   // field positions
   localparam int BIT_IRQ_REQ = 6; // interrupt_control_zero
   localparam int BIT_IRQ_EN = 3;
   localparam int BIT_GLB_EN = 0;
   localparam int BIT_SLEEP = 0; // bus_status_ctrl_reg
   localparam int BIT_RESUME = 1;
   localparam int BIT_WAKE = 2;
   localparam int BIT_CLK_GATE = 0; // bus_clock_ctrl_reg
   localparam int BIT_DEEP = 1;

   // =========================================================
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // =========================================================
   // suspend sequencer states
   typedef enum logic [1:0]
   {
      ST_ACTIVE = 2'b00,
      ST_SUSPEND = 2'b01,
      ST_RESUMING = 2'b10
   } usbsw_state_type;

   // signals from the serial interface engine side
   typedef struct packed
   {
      logic bus_active;
      logic host_resume;
      logic bus_reset;
      logic [7:0] ep_access;
      logic [7:0] sie_we;
      logic [7:0] sie_wdata;
   } usbsw_link_in_type;

   // signals toward the transceiver and clock control
   typedef struct packed
   {
      logic suspended;
      logic remote_wake;
      logic usb_clk_en;
      logic deep_sleep;
   } usbsw_link_out_type;

endpackage

// ==== design/usbsw_top.sv ====
// suspend, resume, remote wake-up and usb interrupt logic with the
// eight endpoint pipe byte ports, as an ahb-lite slave.
// assumes one master, single word transfers and sie inputs that are
// synchronous to hclk.
//
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

// Overview of operation
// - over 3 ms of bus silence enters suspend, sets sleep flag, raises request
// - deep sleep bit during suspend drives the lower power output
// - host resume wakes device, sets resume flag and raises request
// - leaving suspend clears deep sleep bit and resume flag
// - setting remote wake bit while suspended emits a remote wake-up pulse
// - suspend, resume, bus reset and pipe access all raise request
// - pipe access flag interrupts only with pipe and its enable set
// - suspend and resume need no enable inside the usb logic
// - sleep and resume flags are read only, set by hardware
// - request is taken only with usb and global enables set
// - request is taken only while the return stack is not full
// - eight byte-wide read/write pipe ports, not reset
// - one request flag and one enable bit for the usb source
// - per endpoint input buffer enable bit gates its access interrupt
module usbsw_top
#(
   parameter int IDLE_CYCLES = usbsw_pkg::IDLE_CYCLES,
   parameter int WAKE_CYCLES = usbsw_pkg::WAKE_CYCLES
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire usbsw_pkg::usbsw_link_in_type link_in,
   output usbsw_pkg::usbsw_link_out_type link_out,
   input wire logic stack_full,
   input wire logic irq_ack,
   output logic irq_take,
   output logic [63:0] pipe_bytes
);
   import usbsw_pkg::*;

   localparam int IW = $clog2(IDLE_CYCLES + 1);
   localparam int WW = $clog2(WAKE_CYCLES + 1);
   localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_CYCLES);
   localparam logic [WW-1:0] WAKE_LOAD = WW'(WAKE_CYCLES);

   // =========================================================
   // state declarations
   usbsw_state_type state_reg, state_next;
   logic [IW-1:0] idle_cnt_reg, idle_cnt_next;
   logic [WW-1:0] wake_cnt_reg, wake_cnt_next;
   logic irq_req_reg, irq_req_next;
   logic irq_en_reg, irq_en_next;
   logic glb_en_reg, glb_en_next;
   logic wake_req_reg, wake_req_next;
   logic clk_gate_reg, clk_gate_next;
   logic deep_reg, deep_next;
   logic [7:0] in_en_reg, in_en_next;
   logic [7:0] ep_ien_reg, ep_ien_next;
   logic [7:0] ep_flag_reg, ep_flag_next;
   logic [7:0] ep_pend_reg, ep_pend_next;
   logic [7:0] pipe_reg [8];
   logic [7:0] pipe_next [8];
   logic wr_pend_reg, wr_pend_next;
   logic [7:0] wr_addr_reg, wr_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic enter_sleep, resume_ev, leave_sleep, ep_new, usb_event;
   logic wr_now, rd_now;
   logic [7:0] wdat;

   // is the byte offset one of the eight pipe ports
   function automatic logic is_pipe(input logic [7:0] a);
      is_pipe = (a >= OFS_PIPE0) && (a < OFS_PIPE_END);
   endfunction

   // pipe index of a pipe offset
   function automatic logic [2:0] pipe_idx(input logic [7:0] a);
      pipe_idx = a[4:2];
   endfunction

   // =========================================================
   // bus decode: zero wait state, always okay
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_reg;
   assign rd_now = hsel && hready && htrans[1] && !hwrite;
   assign wr_now = wr_pend_reg;
   assign wdat = hwdata[7:0];

   // =========================================================
   // suspend sequencer events
   assign enter_sleep = (state_reg == ST_ACTIVE) && !link_in.bus_active
      && (idle_cnt_reg == IDLE_LAST);
   assign resume_ev = (state_reg == ST_SUSPEND)
      && link_in.host_resume;
   // leave once clocks are back and the host talks after its resume
   assign leave_sleep = (state_reg == ST_RESUMING) && clk_gate_reg
      && link_in.bus_active && !link_in.host_resume;
   assign ep_pend_next = ep_flag_reg & in_en_reg & ep_ien_reg;
   assign ep_new = |(ep_pend_next & ~ep_pend_reg);
   // suspend and resume bypass every per-source enable
   assign usb_event = enter_sleep || resume_ev || link_in.bus_reset
      || ep_new;

   // =========================================================
   // suspend and wake-up next state
   always_comb
   begin
      state_next = state_reg;
      idle_cnt_next = idle_cnt_reg;
      wake_cnt_next = wake_cnt_reg;
      if (link_in.bus_active || state_reg != ST_ACTIVE)
      begin
         idle_cnt_next = '0;
      end
      else if (idle_cnt_reg != IDLE_LAST)
      begin
         idle_cnt_next = idle_cnt_reg + 1'b1;
      end
      case (state_reg)
         ST_ACTIVE:
         begin
            if (enter_sleep)
            begin
               state_next = ST_SUSPEND;
            end
         end
         ST_SUSPEND:
         begin
            if (link_in.bus_reset)
            begin
               state_next = ST_ACTIVE;
            end
            else if (resume_ev)
            begin
               state_next = ST_RESUMING;
            end
         end
         ST_RESUMING:
         begin
            if (leave_sleep || link_in.bus_reset)
            begin
               state_next = ST_ACTIVE;
            end
         end
         default:
         begin
            state_next = ST_ACTIVE;
         end
      endcase
      // a fresh write of one while suspended starts the wake pulse
      if (wr_now && wr_addr_reg == OFS_STATUS && wdat[BIT_WAKE]
         && !wake_req_reg && state_reg == ST_SUSPEND)
      begin
         wake_cnt_next = WAKE_LOAD;
      end
      else if (wake_cnt_reg != '0)
      begin
         wake_cnt_next = wake_cnt_reg - 1'b1;
      end
   end

   // =========================================================
   // register file next values; hardware set beats software clear
   always_comb
   begin
      irq_en_next = irq_en_reg;
      glb_en_next = glb_en_reg;
      wake_req_next = wake_req_reg;
      clk_gate_next = clk_gate_reg;
      deep_next = deep_reg;
      in_en_next = in_en_reg;
      ep_ien_next = ep_ien_reg;
      ep_flag_next = ep_flag_reg;
      irq_req_next = irq_req_reg;
      for (int i = 0; i < 8; i++)
      begin
         pipe_next[i] = link_in.sie_we[i] ? link_in.sie_wdata : pipe_reg[i];
      end
      if (wr_now)
      begin
         case (wr_addr_reg)
            OFS_IRQC:
            begin
               irq_req_next = wdat[BIT_IRQ_REQ];
               irq_en_next = wdat[BIT_IRQ_EN];
               glb_en_next = wdat[BIT_GLB_EN];
            end
            OFS_STATUS: wake_req_next = wdat[BIT_WAKE];
            OFS_CLOCK:
            begin
               clk_gate_next = wdat[BIT_CLK_GATE];
               deep_next = wdat[BIT_DEEP];
            end
            OFS_IN_EN: in_en_next = wdat;
            OFS_EP_IEN: ep_ien_next = wdat;
            OFS_EP_FLAG: ep_flag_next = ep_flag_reg & wdat;
            default:
            begin
               if (is_pipe(wr_addr_reg))
               begin
                  pipe_next[pipe_idx(wr_addr_reg)] = wdat;
               end
            end
         endcase
      end
      if (irq_ack)
      begin
         irq_req_next = 1'b0;
      end
      if (usb_event)
      begin
         irq_req_next = 1'b1;
      end
      ep_flag_next = ep_flag_next | link_in.ep_access;
      // leaving suspend by any route, bus reset included, drops deep sleep
      if (state_reg != ST_ACTIVE && state_next == ST_ACTIVE)
      begin
         deep_next = 1'b0;
      end
   end

   // =========================================================
   // bus phase and read data next values; reads see pending writes
   always_comb
   begin
      wr_pend_next = hsel && hready && htrans[1] && hwrite;
      wr_addr_next = haddr[7:0];
      hrdata_next = hrdata_reg;
      if (rd_now)
      begin
         hrdata_next = RST_WORD;
         case (haddr[7:0])
            OFS_IRQC:
            begin
               hrdata_next[BIT_IRQ_REQ] = irq_req_next;
               hrdata_next[BIT_IRQ_EN] = irq_en_next;
               hrdata_next[BIT_GLB_EN] = glb_en_next;
            end
            OFS_STATUS:
            begin
               hrdata_next[BIT_SLEEP] = (state_next != ST_ACTIVE);
               hrdata_next[BIT_RESUME] = (state_next == ST_RESUMING);
               hrdata_next[BIT_WAKE] = wake_req_next;
            end
            OFS_CLOCK:
            begin
               hrdata_next[BIT_CLK_GATE] = clk_gate_next;
               hrdata_next[BIT_DEEP] = deep_next;
            end
            OFS_IN_EN: hrdata_next[7:0] = in_en_next;
            OFS_EP_IEN: hrdata_next[7:0] = ep_ien_next;
            OFS_EP_FLAG: hrdata_next[7:0] = ep_flag_next;
            default:
            begin
               if (is_pipe(haddr[7:0]))
               begin
                  hrdata_next[7:0] = pipe_next[pipe_idx(haddr[7:0])];
               end
            end
         endcase
      end
   end

   // =========================================================
   // control registers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         state_reg <= ST_ACTIVE;
         idle_cnt_reg <= '0;
         wake_cnt_reg <= '0;
         irq_req_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         glb_en_reg <= 1'b0;
         wake_req_reg <= 1'b0;
         clk_gate_reg <= 1'b0;
         deep_reg <= 1'b0;
         in_en_reg <= RST_BYTE;
         ep_ien_reg <= RST_BYTE;
         ep_flag_reg <= RST_BYTE;
         ep_pend_reg <= RST_BYTE;
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= RST_BYTE;
         hrdata_reg <= RST_WORD;
      end
      else
      begin
         state_reg <= state_next;
         idle_cnt_reg <= idle_cnt_next;
         wake_cnt_reg <= wake_cnt_next;
         irq_req_reg <= irq_req_next;
         irq_en_reg <= irq_en_next;
         glb_en_reg <= glb_en_next;
         wake_req_reg <= wake_req_next;
         clk_gate_reg <= clk_gate_next;
         deep_reg <= deep_next;
         in_en_reg <= in_en_next;
         ep_ien_reg <= ep_ien_next;
         ep_flag_reg <= ep_flag_next;
         ep_pend_reg <= ep_pend_next;
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg <= hrdata_next;
      end
   end

   // pipe bytes power up unknown, so they carry no reset
   always_ff @(posedge hclk)
   begin
      for (int i = 0; i < 8; i++)
      begin
         pipe_reg[i] <= pipe_next[i];
      end
   end

   // =========================================================
   // outputs toward the link and the processor core
   assign link_out.suspended = (state_reg != ST_ACTIVE);
   assign link_out.remote_wake = (wake_cnt_reg != '0);
   assign link_out.usb_clk_en = clk_gate_reg;
   // deep sleep only counts while suspended
   assign link_out.deep_sleep = deep_reg
      && (state_reg != ST_ACTIVE);
   assign irq_take = irq_req_reg && irq_en_reg && glb_en_reg
      && !stack_full;
   always_comb
   begin
      for (int i = 0; i < 8; i++)
      begin
         pipe_bytes[i*8 +: 8] = pipe_reg[i];
      end
   end

   // =========================================================
   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_idle_done;
      state_reg == ST_ACTIVE && !link_in.bus_active
         && idle_cnt_reg == IDLE_LAST;
   endsequence
   sequence s_host_resume;
      state_reg == ST_SUSPEND && link_in.host_resume && !link_in.bus_reset;
   endsequence

   property p_suspend_entry;
      s_idle_done |=> state_reg == ST_SUSPEND && irq_req_reg;
   endproperty
   a_suspend_entry: assert property (p_suspend_entry)
      else $error("suspend not entered after bus silence");

   property p_deep_only_suspended;
      link_out.deep_sleep |-> link_out.suspended && deep_reg;
   endproperty
   a_deep_only_suspended: assert property (p_deep_only_suspended)
      else $error("deep sleep output outside suspend");

   property p_host_resume;
      s_host_resume |=> state_reg == ST_RESUMING && irq_req_reg;
   endproperty
   a_host_resume: assert property (p_host_resume)
      else $error("host resume did not wake the device");

   property p_leave_clears;
      state_reg != ST_ACTIVE ##1 state_reg == ST_ACTIVE
         |-> !deep_reg && !link_out.suspended;
   endproperty
   a_leave_clears: assert property (p_leave_clears)
      else $error("deep sleep left set after leaving suspend");

   property p_wake_pulse;
      wr_now && wr_addr_reg == OFS_STATUS && wdat[BIT_WAKE] && !wake_req_reg
         && state_reg == ST_SUSPEND |=> link_out.remote_wake [*2];
   endproperty
   a_wake_pulse: assert property (p_wake_pulse)
      else $error("remote wake pulse missing");

   property p_event_sets;
      usb_event |=> irq_req_reg;
   endproperty
   a_event_sets: assert property (p_event_sets)
      else $error("usb event lost");

   property p_flag_kept;
      ep_flag_reg[0] && !(wr_now && wr_addr_reg == OFS_EP_FLAG)
         |=> ep_flag_reg[0];
   endproperty
   a_flag_kept: assert property (p_flag_kept)
      else $error("endpoint flag cleared by hardware");

   property p_gated_take;
      !glb_en_reg || !irq_en_reg || stack_full |-> !irq_take;
   endproperty
   a_gated_take: assert property (p_gated_take)
      else $error("interrupt taken while gated");

   property p_sticky;
      irq_req_reg && !irq_ack && !(wr_now && wr_addr_reg == OFS_IRQC)
         |=> irq_req_reg;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("request flag dropped on its own");

   property p_gate_ep;
      ep_flag_reg[1] && !in_en_reg[1] |-> !ep_pend_next[1];
   endproperty
   a_gate_ep: assert property (p_gate_ep)
      else $error("disabled pipe produced access interrupt");

endmodule

// ==== verification/usbsw_host_model.sv ====
// behavioural usb host facing the suspend and wake-up block:
// bus activity, resume signalling, bus reset and sie strobes.
// assumes bench commands change just after a rising hclk edge.
`timescale 1ns/1ps

module usbsw_host_model
#(
   parameter int ANS_DELAY = 3,
   parameter int RES_CYCLES = 4
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic go_quiet,
   input wire logic wake_host,
   input wire logic bus_reset_cmd,
   input wire logic [7:0] ep_hit,
   input wire logic [7:0] sie_we_cmd,
   input wire logic [7:0] sie_data_cmd,
   input wire usbsw_pkg::usbsw_link_out_type link_out,
   output usbsw_pkg::usbsw_link_in_type link_in
);
   import usbsw_pkg::*;
   logic quiet_reg;
   logic pend_reg;
   logic wake_seen_reg;
   logic [7:0] last_reg;
   int delay_reg;
   int res_reg;

   // =========================================================
   // host sequencing
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         quiet_reg <= 1'b0;
         pend_reg <= 1'b0;
         wake_seen_reg <= 1'b0;
         last_reg <= 8'h00;
         delay_reg <= 0;
         res_reg <= 0;
      end
      else
      begin
         wake_seen_reg <= link_out.remote_wake;
         if (sie_we_cmd != 8'h00)
            last_reg <= sie_data_cmd;
         if (go_quiet)
            quiet_reg <= 1'b1;
         // a finished wake-up pulse is answered with resume
         if (wake_seen_reg && !link_out.remote_wake)
            delay_reg <= ANS_DELAY;
         else if (delay_reg > 0)
            delay_reg <= delay_reg - 1;
         if (wake_host || delay_reg == 1)
         begin
            res_reg <= RES_CYCLES;
            pend_reg <= 1'b1;
         end
         else if (res_reg > 0)
            res_reg <= res_reg - 1;
         // talk again only once the usb clock is back on
         if (pend_reg && res_reg == 0 && link_out.usb_clk_en)
         begin
            quiet_reg <= 1'b0;
            pend_reg <= 1'b0;
         end
         if (bus_reset_cmd)
            quiet_reg <= 1'b0;
      end
   end

   // line levels; a released data byte shows the inverse, not a hold
   always_comb
   begin
      link_in.bus_active = !quiet_reg && res_reg == 0;
      link_in.host_resume = res_reg != 0;
      link_in.bus_reset = bus_reset_cmd;
      link_in.ep_access = ep_hit;
      link_in.sie_we = sie_we_cmd;
      link_in.sie_wdata = (sie_we_cmd != 8'h00) ? sie_data_cmd : ~last_reg;
   end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the usb suspend, wake-up and irq block:
// ahb-lite master tasks, a read monitor with an expectation queue.
// assumes the host model file and the design package are compiled first.
`timescale 1ns/1ps

module tb_top;
   import usbsw_pkg::*;
   localparam int IDLE = 20;
   localparam int WAKE = 5;
   localparam int LIMIT = 20000;
   logic hclk, hresetn, hsel, hwrite, stack_full, irq_ack;
   logic [31:0] haddr, hwdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   wire logic hready;
   logic hreadyout, hresp, irq_take, rd_dphase;
   logic [31:0] hrdata;
   logic [63:0] pipe_bytes;
   usbsw_link_in_type link_in;
   usbsw_link_out_type link_out;
   logic go_quiet, wake_host, bus_reset_cmd;
   logic [7:0] ep_hit, sie_we_cmd, sie_data_cmd;
   logic [31:0] exp_q [$];
   logic [31:0] msk_q [$];
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;

   assign hready = hreadyout;

   usbsw_top #(.IDLE_CYCLES(IDLE), .WAKE_CYCLES(WAKE)) uut (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .link_in(link_in), .link_out(link_out), .stack_full(stack_full),
      .irq_ack(irq_ack), .irq_take(irq_take), .pipe_bytes(pipe_bytes));

   usbsw_host_model host (.hclk(hclk), .hresetn(hresetn),
      .go_quiet(go_quiet), .wake_host(wake_host),
      .bus_reset_cmd(bus_reset_cmd), .ep_hit(ep_hit),
      .sie_we_cmd(sie_we_cmd), .sie_data_cmd(sie_data_cmd),
      .link_out(link_out), .link_in(link_in));

   // =========================================================
   // clock, timeout and read monitor
   always #25 hclk = ~hclk;

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(string what, logic [63:0] seen, logic [63:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
         fail_count++;
      end
   endtask

   // a hang counts as a mismatch and goes straight to the verdict
   always @(posedge hclk)
   begin
      cycles <= cycles + 1;
      if (cycles == LIMIT)
      begin
         fail_count++;
         wrap_up();
      end
   end

   // read data is taken at the edge that ends the data phase
   always @(posedge hclk)
   begin
      logic [31:0] e, m;
      if (rd_dphase === 1'b1 && hready === 1'b1 && exp_q.size() > 0)
      begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         chk("hrdata", hrdata & m, e & m);
      end
      rd_dphase <= hsel && htrans[1] && !hwrite && hready;
   end

   // =========================================================
   // bus tasks: address phase held until hready, then data phase
   task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= {24'h000000, a};
      hwrite <= w;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
   endtask

   task automatic wr(logic [7:0] a, logic [31:0] d);
      bus(a, 1'b1, d);
   endtask

   task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      bus(a, 1'b0, 32'h0000_0000);
   endtask

   // one-cycle strobe on {go_quiet, irq_ack, bus_reset_cmd, wake_host}
   task automatic pulse(logic [3:0] sel);
      @(posedge hclk);
      {go_quiet, irq_ack, bus_reset_cmd, wake_host} <= sel;
      @(posedge hclk);
      {go_quiet, irq_ack, bus_reset_cmd, wake_host} <= 4'h0;
   endtask

   // silence the bus, measure the span to suspend, clear the request
   task automatic go_suspend();
      n = 0;
      pulse(4'h8); // go_quiet
      while (link_out.suspended !== 1'b1) begin @(negedge hclk); n++; end
      chk("idle span", n >= IDLE && n <= IDLE + 4, 1);
      chk("irq_take", irq_take, 1);
      rd(OFS_STATUS, 32'h1, 32'h1);
      wr(OFS_IRQC, 32'h09);
   endtask

   // =========================================================
   // main sequence
   initial
   begin
      logic [7:0] pd [8];
      logic [63:0] pexp;
      logic [31:0] v;
      logic [7:0] m;
      hclk = 0;
      hresetn = 0;
      {hsel, hwrite, stack_full, irq_ack} = '0;
      {haddr, hwdata, htrans} = '0;
      hsize = 3'b010;
      {go_quiet, wake_host, bus_reset_cmd} = '0;
      {ep_hit, sie_we_cmd, sie_data_cmd} = '0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      void'($urandom(36632));
      // reset values, an unmapped word and the okay response
      foreach (pd[i]) rd(8'h00 + 8'(4 * (i % 6)), 0, 32'hFFFF_FFFF);
      wr(8'h18, 32'hFFFF_FFFF);
      rd(8'h18, 0, 32'hFFFF_FFFF);
      chk("hresp", hresp, 0);
      chk("link_out", 64'(link_out), 0);
      $display("test reset done");
      // pipes: random bytes, read back, then an sie write
      pexp = '0;
      for (int i = 0; i < 8; i++)
      begin
         pd[i] = 8'($urandom());
         pexp[8 * i +: 8] = pd[i];
         wr(OFS_PIPE0 + 8'(4 * i), {24'hFFFFFF, pd[i]});
      end
      foreach (pd[i]) rd(OFS_PIPE0 + 8'(4 * i), {24'h0, pd[i]}, '1);
      chk("pipe_bytes", pipe_bytes, pexp);
      @(posedge hclk);
      sie_we_cmd <= 8'h08;
      sie_data_cmd <= ~pd[3];
      @(posedge hclk);
      sie_we_cmd <= 8'h00;
      rd(OFS_PIPE0 + 8'h0C, {24'h0, ~pd[3]}, '1);
      $display("test pipes done");
      // request with every enable and stack combination
      for (int k = 0; k < 8; k++)
      begin
         v = 32'h40 | (k[1] ? 32'h08 : 32'h0) | (k[0] ? 32'h1 : 32'h0);
         wr(OFS_IRQC, v);
         stack_full <= k[2];
         @(negedge hclk);
         chk("irq_take", irq_take, k == 3);
      end
      stack_full <= 1'b0;
      repeat (6) @(negedge hclk);
      rd(OFS_IRQC, 32'h49, '1);
      pulse(4'h4); // irq_ack
      @(negedge hclk);
      chk("irq_take", irq_take, 0);
      rd(OFS_IRQC, 32'h09, '1);
      $display("test request done");
      // suspend, read-only flags, clock gate and deep sleep
      go_suspend();
      wr(OFS_STATUS, 32'h2);
      rd(OFS_STATUS, 32'h1, 32'h3);
      wr(OFS_CLOCK, 32'h2);
      @(negedge hclk);
      chk("deep_sleep", link_out.deep_sleep, 1);
      chk("usb_clk_en", link_out.usb_clk_en, 0);
      // remote wake-up, host answer, leaving suspend
      wr(OFS_STATUS, 32'h4);
      while (link_out.remote_wake !== 1'b1) @(negedge hclk);
      n = 0;
      while (link_out.remote_wake === 1'b1) begin @(negedge hclk); n++; end
      chk("wake pulse", n, WAKE);
      while (irq_take !== 1'b1) @(negedge hclk);
      rd(OFS_STATUS, 32'h6, 32'h6);
      wr(OFS_CLOCK, 32'h3);
      while (link_in.bus_active !== 1'b1) @(negedge hclk);
      repeat (2) @(negedge hclk);
      rd(OFS_CLOCK, 32'h1, 32'h3);
      rd(OFS_STATUS, 32'h4, 32'h7);
      wr(OFS_IRQC, 32'h09);
      wr(OFS_STATUS, 32'h0);
      // a wake request while active gives no pulse
      wr(OFS_STATUS, 32'h4);
      n = 0;
      repeat (WAKE + 4) begin @(negedge hclk); n += link_out.remote_wake; end
      chk("wake refused", n, 0);
      wr(OFS_STATUS, 32'h0);
      $display("test wake done");
      // bus reset in suspend, then a host started resume
      go_suspend();
      pulse(4'h2); // bus_reset_cmd
      @(negedge hclk);
      chk("suspended", link_out.suspended, 0);
      chk("irq_take", irq_take, 1);
      wr(OFS_IRQC, 32'h09);
      go_suspend();
      pulse(4'h1); // wake_host
      while (irq_take !== 1'b1) @(negedge hclk);
      rd(OFS_STATUS, 32'h2, 32'h2);
      while (link_in.bus_active !== 1'b1) @(negedge hclk);
      repeat (2) @(negedge hclk);
      rd(OFS_STATUS, 32'h0, 32'h3);
      wr(OFS_IRQC, 32'h09);
      $display("test reset and resume done");
      // endpoint access flags and their two gates
      for (int e = 0; e < 8; e++)
      begin
         m = 8'h01 << e;
         @(posedge hclk);
         ep_hit <= m;
         @(posedge hclk);
         ep_hit <= 8'h00;
         rd(OFS_EP_FLAG, {24'h0, m}, '1);
         wr(OFS_IN_EN, {24'h0, m});
         @(negedge hclk);
         chk("irq_take", irq_take, 0);
         wr(OFS_EP_IEN, {24'h0, m});
         repeat (2) @(negedge hclk);
         chk("irq_take", irq_take, 1);
         rd(OFS_EP_FLAG, {24'h0, m}, '1);
         wr(OFS_EP_FLAG, {24'h0, ~m});
         rd(OFS_EP_FLAG, 32'h0, '1);
         wr(OFS_IN_EN, 32'h0);
         wr(OFS_EP_IEN, 32'h0);
         wr(OFS_IRQC, 32'h09);
      end
      $display("test endpoints done");
      repeat (3) @(posedge hclk);
      wrap_up();
   end
endmodule
